// ---- design/cpu_clock_mode_select.sv ----
/*
 cpu clock mode selector: holds the reset configuration latch and builds the
 cpu clock from the oscillator by pll multiplication, direct drive or a 2:1
 prescaler, flagging every cpu clock edge.
 assumes the oscillator and port pins are asynchronous to clk, and that
 longHwReset, reloadFromSoftware and resetControlReg come from clk logic.
 the cpu clock is a sampled image on the 125 MHz grid, so its edges carry
 up to one clk period of quantisation.
*/
`timescale 1ns/10ps
module cpu_clock_mode_select
   import cpu_clock_pkg::*;
(
   input  wire logic                clk,
   input  wire logic                rst,
   input  wire logic                longHwReset,
   input  wire logic                reloadFromSoftware,
   input  wire logic [RCR_W-1:0]    resetControlReg,
   input  wire logic [LATCH_W-1:0]  port0UpperByte,
   input  wire logic                oscIn,
   output logic [LATCH_W-1:0]       resetConfigLatch,
   output logic [CFG_W-1:0]         clockGenSelectField,
   output logic                     pllEnable,
   output logic                     directDrive,
   output logic                     prescalerOn,
   output logic                     cpuClk,
   output logic                     cpuRise,
   output logic                     cpuFall,
   output logic [PERIOD_W-1:0]      clockHalfPeriod
);

   logic [LATCH_W-1:0]  portS1_r;
   logic [LATCH_W-1:0]  portS2_r;
   logic                oscS1_r;
   logic                oscS2_r;
   logic                oscS3_r;
   logic                oscRise;
   logic                oscEdge;
   logic [LATCH_W-1:0]  resetConfigLatch_r;
   logic [CFG_W-1:0]    cfg;
   logic [CFG_W-1:0]    cfgPrev_r;
   logic                cfgChanged;
   logic                isPll;
   logic [NUM_W-1:0]    halves;
   logic [NUM_W-1:0]    syncLen;
   logic [PERIOD_W-1:0] periodMeas;
   logic                measValid;
   logic [PERIOD_W-1:0] periodEst_r;
   logic                periodOk_r;
   logic [PERIOD_W:0]   periodDiff;
   logic [PERIOD_W:0]   periodStep;
   logic [PERIOD_W-1:0] periodAdj;
   clk_state_t          state_r;
   clk_state_t          state_nxt;
   logic [ACC_W-1:0]    acc_r;
   logic [ACC_W-1:0]    accSum;
   logic                pllToggle;
   logic [NUM_W-1:0]    edgeCnt_r;
   logic                resync;
   logic                cpuClk_r;
   logic                cpuClk_nxt;
   logic [PERIOD_W-1:0] tclCnt_r;

   // two-stage synchronisers for the port pins and the oscillator
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         portS1_r <= 8'h00;
         portS2_r <= 8'h00;
         oscS1_r  <= 1'b0;
         oscS2_r  <= 1'b0;
         oscS3_r  <= 1'b0;
      end
      else
      begin
         portS1_r <= port0UpperByte;
         portS2_r <= portS1_r;
         oscS1_r  <= oscIn;
         oscS2_r  <= oscS1_r;
         oscS3_r  <= oscS2_r;
      end
   end

   // oscillator edges seen on the synchronised copy
   assign oscRise = oscS2_r & ~oscS3_r;
   assign oscEdge = oscS2_r ^ oscS3_r;

   // reset configuration latch; a long reset outranks a software reload
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         resetConfigLatch_r <= RESET_CONFIG_DEFAULT;
      else if (longHwReset)
         resetConfigLatch_r <= portS2_r;
      else if (reloadFromSoftware)
         resetConfigLatch_r <= resetControlReg[RCR_HI_MSB:RCR_HI_LSB];
   end

   assign resetConfigLatch    = resetConfigLatch_r;
   assign clockGenSelectField = resetConfigLatch_r[CFG_MSB:CFG_LSB];

   // mode decode from the latched field
   assign cfg     = resetConfigLatch_r[CFG_MSB:CFG_LSB];
   assign isPll   = (cfg != CFG_DIRECT) && (cfg != CFG_DIV2);
   assign halves  = halvesPerOsc(cfg);
   assign syncLen = syncTransitions(cfg);

   // registered mode indications
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         pllEnable   <= 1'b0;
         directDrive <= 1'b0;
         prescalerOn <= 1'b0;
         cfgPrev_r   <= CFG_X4;
      end
      else
      begin
         pllEnable   <= isPll;
         directDrive <= (cfg == CFG_DIRECT);
         prescalerOn <= (cfg == CFG_DIV2);
         cfgPrev_r   <= cfg;
      end
   end

   assign cfgChanged = (cfg != cfgPrev_r);

   // oscillator period measurement
   osc_period_meter u_meter
   (
      .clk        (clk),
      .rst        (rst),
      .oscRise    (oscRise),
      .periodMeas (periodMeas),
      .measValid  (measValid)
   );

   // smoothed period estimate so the pll output never jumps
   assign periodDiff = {1'b0, periodMeas} - {1'b0, periodEst_r};
   assign periodStep = {{SMOOTH_SHIFT{periodDiff[PERIOD_W]}}, periodDiff[PERIOD_W:SMOOTH_SHIFT]};
   // a small positive error would truncate to zero and leave the estimate short for good
   assign periodAdj  = (periodStep == 17'h00000 && periodDiff != 17'h00000) ? 16'h0001
                                                                            : periodStep[PERIOD_W-1:0];

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         periodEst_r <= 16'h0000;
         periodOk_r  <= 1'b0;
      end
      else if (measValid)
      begin
         periodOk_r <= 1'b1;
         if (!periodOk_r)
            periodEst_r <= periodMeas;
         else
            periodEst_r <= periodEst_r + periodAdj;
      end
   end

   // engine state: hold after a mode change until pll has a period
   always_comb
   begin
      state_nxt = state_r;
      case (state_r)
         ST_HOLD:
            if (!cfgChanged && (!isPll || periodOk_r))
               state_nxt = ST_RUN;
         ST_RUN:
            if (cfgChanged)
               state_nxt = ST_HOLD;
         default:
            state_nxt = ST_HOLD;
      endcase
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         state_r <= ST_HOLD;
      else
         state_r <= state_nxt;
   end

   // oscillator transition counter marking each resync point
   assign resync = oscEdge && (edgeCnt_r == syncLen - 4'h1);

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         edgeCnt_r <= 4'h0;
      else if (state_r != ST_RUN)
         edgeCnt_r <= 4'h0;
      else if (resync)
         edgeCnt_r <= 4'h0;
      else if (oscEdge)
         edgeCnt_r <= edgeCnt_r + 4'h1;
   end

   // phase accumulator: 2F half periods per oscillator period
   assign accSum    = acc_r + {13'h0000, halves};
   assign pllToggle = (accSum >= {1'b0, periodEst_r});

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         acc_r <= 17'h00000;
      else if (state_r != ST_RUN || !isPll)
         acc_r <= 17'h00000;
      else if (pllToggle)
         acc_r <= accSum - {1'b0, periodEst_r};
      else if (resync)
         acc_r <= accSum - {4'h0, acc_r[ACC_W-1:4]};                      // pull phase a little, no jump
      else
         acc_r <= accSum;
   end

   // cpu clock source selection per mode
   always_comb
   begin
      cpuClk_nxt = cpuClk_r;
      if (state_r == ST_RUN)
      begin
         case (cfg)
            CFG_DIRECT:
               cpuClk_nxt = oscS2_r;
            CFG_DIV2:
               if (oscRise)
                  cpuClk_nxt = ~cpuClk_r;
            default:
               if (pllToggle)
                  cpuClk_nxt = ~cpuClk_r;
         endcase
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         cpuClk_r <= 1'b0;
      else
         cpuClk_r <= cpuClk_nxt;
   end

   assign cpuClk = cpuClk_r;

   // edge flags: each cpu clock edge starts a new half period
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         cpuRise <= 1'b0;
         cpuFall <= 1'b0;
      end
      else
      begin
         cpuRise <= cpuClk_nxt & ~cpuClk_r;
         cpuFall <= ~cpuClk_nxt & cpuClk_r;
      end
   end

   // length of the last completed half period in clk cycles
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         tclCnt_r        <= 16'h0000;
         clockHalfPeriod <= 16'h0000;
      end
      else if (cpuClk_nxt != cpuClk_r)
      begin
         tclCnt_r        <= 16'h0000;
         clockHalfPeriod <= tclCnt_r + 16'h0001;
      end
      else if (tclCnt_r != PERIOD_MAX)
         tclCnt_r <= tclCnt_r + 16'h0001;
   end

endmodule

// ---- design/cpu_clock_pkg.sv ----
/*
 constants, types and helper functions for the cpu clock mode selector.
 assumes a single 125 MHz system clock; the oscillator reaches the block as a pin.
*/
// Behaviour
// - clock mode comes from latch bits 7..5
// - long hardware reset loads latch from port
// - software reloads latch from control upper half
// - decode eight codes into factors and modes
// - prescaler halves the oscillator frequency
// - prescaler phases each last one oscillator period
// - multiplying codes enable pll, f times oscillator
// - pll resyncs every f-th transition, every 2f-th for fractional f, gradually
// - direct drive follows oscillator, pll off
// - direct drive phase pair spans one period
// - both cpu clock edges flagged as timing units
package cpu_clock_pkg;

   localparam int LATCH_W     = 8;
   localparam int CFG_W       = 3;
   localparam int CFG_MSB     = 7;
   localparam int CFG_LSB     = 5;
   localparam int RCR_W       = 16;
   localparam int RCR_HI_MSB  = 15;
   localparam int RCR_HI_LSB  = 8;
   localparam int PERIOD_W    = 16;
   localparam int ACC_W       = 17;
   localparam int NUM_W       = 4;
   localparam int SMOOTH_SHIFT = 2;

   localparam logic [LATCH_W-1:0]  RESET_CONFIG_DEFAULT = 8'hff;
   localparam logic [PERIOD_W-1:0] PERIOD_MAX           = 16'hffff;

   // clock generation codes, value of the select field
   typedef enum logic [CFG_W-1:0]
   {
      CFG_X2P5   = 3'b000,
      CFG_DIV2   = 3'b001,
      CFG_X1P5   = 3'b010,
      CFG_DIRECT = 3'b011,
      CFG_X5     = 3'b100,
      CFG_X2     = 3'b101,
      CFG_X3     = 3'b110,
      CFG_X4     = 3'b111
   } clock_cfg_t;

   // clock engine state
   typedef enum logic [0:0]
   {
      ST_HOLD = 1'b0,
      ST_RUN  = 1'b1
   } clk_state_t;

   // cpu half periods per oscillator period, i.e. twice the factor, except 2 for the prescaler code
   function automatic logic [NUM_W-1:0] halvesPerOsc(input logic [CFG_W-1:0] cfg);
      logic [NUM_W-1:0] n;
      n = 4'h0;
      case (cfg)
         CFG_X4:   n = 4'h8;
         CFG_X3:   n = 4'h6;
         CFG_X2:   n = 4'h4;
         CFG_X5:   n = 4'ha;
         CFG_X1P5: n = 4'h3;
         CFG_X2P5: n = 4'h5;
         default:  n = 4'h2;
      endcase
      return n;
   endfunction

   // oscillator transitions between two resyncs: the factor, doubled when fractional
   function automatic logic [NUM_W-1:0] syncTransitions(input logic [CFG_W-1:0] cfg);
      logic [NUM_W-1:0] n;
      n = halvesPerOsc(cfg);
      return n[0] ? n : {1'b0, n[NUM_W-1:1]};
   endfunction

endpackage

// ---- design/osc_period_meter.sv ----
/*
 measures the oscillator period in system clock cycles, rising edge to rising edge.
 assumes oscRise is a one-cycle pulse already synchronised to clk.
*/
`timescale 1ns/10ps
module osc_period_meter
   import cpu_clock_pkg::*;
(
   input  wire logic                clk,
   input  wire logic                rst,
   input  wire logic                oscRise,
   output logic [PERIOD_W-1:0]      periodMeas,
   output logic                     measValid
);

   logic [PERIOD_W-1:0] cnt_r;
   logic                armed_r;

   // saturating cycle counter, restarted on each rising edge
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         cnt_r <= 16'h0000;
      else if (oscRise)
         cnt_r <= 16'h0001;
      else if (cnt_r != PERIOD_MAX)
         cnt_r <= cnt_r + 16'h0001;
   end

   // first edge only arms; later edges report a full period
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         armed_r    <= 1'b0;
         periodMeas <= 16'h0000;
         measValid  <= 1'b0;
      end
      else
      begin
         measValid <= oscRise & armed_r;
         if (oscRise)
         begin
            armed_r    <= 1'b1;
            periodMeas <= cnt_r;
         end
      end
   end

endmodule

// ---- test/cpu_clock_mode_select_monitor.sv ----
/* port checker for the cpu clock mode selector.
 assumes it is bound to cpu_clock_mode_select. */
`timescale 1ns/10ps
module cpu_clock_mode_select_monitor
   import cpu_clock_pkg::*;
(
   input wire logic               clk,
   input wire logic               rst,
   input wire logic               longHwReset,
   input wire logic               reloadFromSoftware,
   input wire logic [RCR_W-1:0]   resetControlReg,
   input wire logic [LATCH_W-1:0] port0UpperByte,
   input wire logic               oscIn,
   input wire logic [LATCH_W-1:0] resetConfigLatch,
   input wire logic [CFG_W-1:0]   clockGenSelectField,
   input wire logic               pllEnable,
   input wire logic               directDrive,
   input wire logic               prescalerOn,
   input wire logic               cpuClk,
   input wire logic               cpuRise,
   input wire logic               cpuFall
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   // upper half of the control value, watched by the reload check
   wire logic [LATCH_W-1:0] ctlHi = resetControlReg[RCR_HI_MSB:RCR_HI_LSB];
   // latch contents and mode flags
   chk_field_mirror: assert property (clockGenSelectField == resetConfigLatch[CFG_MSB:CFG_LSB])
      else $error("field differs from latch");
   chk_port_load: assert property ($stable(port0UpperByte) [*4] ##0 longHwReset |=> resetConfigLatch == port0UpperByte)
      else $error("latch missed port level");
   chk_soft_reload: assert property (reloadFromSoftware && !longHwReset |=> resetConfigLatch == $past(ctlHi))
      else $error("latch missed reload");
   chk_direct_decode: assert property (clockGenSelectField == CFG_DIRECT |=> directDrive && !pllEnable && !prescalerOn)
      else $error("direct code decoded wrong");
   chk_div_decode: assert property (clockGenSelectField == CFG_DIV2 |=> prescalerOn && !pllEnable && !directDrive)
      else $error("prescaler code decoded wrong");
   chk_pll_decode: assert property (!(clockGenSelectField inside {CFG_DIRECT, CFG_DIV2}) |=> pllEnable && !directDrive)
      else $error("pll code decoded wrong");
   // cpu clock edges and timing
   chk_rise_flag: assert property (cpuRise == (cpuClk && !$past(cpuClk)))
      else $error("rise flag wrong");
   chk_fall_flag: assert property (cpuFall == (!cpuClk && $past(cpuClk)))
      else $error("fall flag wrong");
   chk_direct_follow: assert property (directDrive && $past(directDrive, 6) |-> cpuClk == $past(oscIn, 3))
      else $error("direct clock not following oscillator");
   chk_div_toggle: assert property (prescalerOn && $rose(oscIn) |-> ##[2:5] (cpuRise || cpuFall))
      else $error("prescaler missed oscillator rise");
   cov_div: cover property (prescalerOn && cpuRise);
   cov_direct: cover property (directDrive && cpuFall);
   cov_pll: cover property (pllEnable && cpuRise);
endmodule

// ---- test/osc_source.sv ----
/* oscillator source for the cpu clock bench.
 assumes phase times change only while run is low. */
`timescale 1ns/10ps
module osc_source
(
   input  wire logic        run,
   input  wire logic [31:0] highNs,
   input  wire logic [31:0] lowNs,
   output logic             osc
);
   // square wave while run is high, parked low between runs
   initial
   begin
      osc = 1'b0;
      forever
      begin
         if (run !== 1'b1)
         begin
            @(posedge run);
            #3;
         end
         osc = 1'b1;
         #(highNs);
         osc = 1'b0;
         #(lowNs);
      end
   end
endmodule

// ---- test/tb_top.sv ----
/* self-checking bench for the cpu clock mode selector.
 assumes the package, design and osc_source are compiled first. */
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin err_total++; $display("mismatch %s exp %0h got %0h", nm, ex, got); end end
module tb_top
   import cpu_clock_pkg::*;
;
   logic                clk;
   logic                rst;
   logic                longHwReset;
   logic                reloadFromSoftware;
   logic [RCR_W-1:0]    resetControlReg;
   logic [LATCH_W-1:0]  port0UpperByte;
   logic                oscIn;
   logic                oscRun;
   int                  oscHigh;
   int                  oscLow;
   logic [LATCH_W-1:0]  resetConfigLatch;
   logic [CFG_W-1:0]    clockGenSelectField;
   logic                pllEnable;
   logic                directDrive;
   logic                prescalerOn;
   logic                cpuClk;
   logic                cpuRise;
   logic                cpuFall;
   logic [PERIOD_W-1:0] clockHalfPeriod;
   int                  err_total;
   int                  num_checks;

   cpu_clock_mode_select dut (.clk, .rst, .longHwReset, .reloadFromSoftware, .resetControlReg, .port0UpperByte,
      .oscIn, .resetConfigLatch, .clockGenSelectField, .pllEnable, .directDrive, .prescalerOn, .cpuClk, .cpuRise,
      .cpuFall, .clockHalfPeriod);
   osc_source osc (.run(oscRun), .highNs(oscHigh), .lowNs(oscLow), .osc(oscIn));

   // 125 MHz system clock
   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   task automatic finish_test();
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // park the oscillator, reload the latch and check the decoded mode
   task automatic load_mode(input logic [2:0] code);
      logic [7:0] hi;
      hi = {code, 5'h0a};
      oscRun = 1'b0;
      repeat (60) @(negedge clk);
      resetControlReg = {hi, 8'h5c};
      reloadFromSoftware = 1'b1;
      @(negedge clk);
      reloadFromSoftware = 1'b0;
      repeat (3) @(negedge clk);
      `CHK("latch", hi, resetConfigLatch)
      `CHK("field", code, clockGenSelectField)
      `CHK("pll", code != 3'b011 && code != 3'b001, pllEnable)
      `CHK("direct", code == 3'b011, directDrive)
      `CHK("prescale", code == 3'b001, prescalerOn)
   endtask

   // one high and one low cpu clock phase, in clk cycles
   task automatic measure(output int hi, output int lo);
      int n;
      n = 0;
      while (cpuRise !== 1'b1 && n < 400)
      begin
         @(negedge clk);
         n++;
      end
      hi = 0;
      do
      begin
         @(negedge clk);
         hi++;
      end while (cpuFall !== 1'b1 && hi < 400);
      `CHK("half high", 16'(hi), clockHalfPeriod)
      lo = 0;
      do
      begin
         @(negedge clk);
         lo++;
      end while (cpuRise !== 1'b1 && lo < 400);
      `CHK("half low", 16'(lo), clockHalfPeriod)
   endtask

   task automatic test_hw_reset();
      port0UpperByte = 8'h65;
      resetControlReg = 16'h2200;
      reloadFromSoftware = 1'b1;
      longHwReset = 1'b1;
      repeat (6) @(negedge clk);
      longHwReset = 1'b0;
      reloadFromSoftware = 1'b0;
      repeat (3) @(negedge clk);
      `CHK("port load", 8'h65, resetConfigLatch)
      `CHK("port mode", 1'b1, directDrive)
      $display("test hw reset done");
   endtask

   // skewed duty input, output must stay one input period per phase
   task automatic test_prescaler();
      int hi, lo;
      load_mode(3'b001);
      oscHigh = 24;
      oscLow = 56;
      oscRun = 1'b1;
      measure(hi, lo);
      measure(hi, lo);
      `CHK("div high", 10, hi)
      `CHK("div low", 10, lo)
      $display("test prescaler done");
   endtask

   task automatic test_direct();
      int hi, lo;
      load_mode(3'b011);
      oscRun = 1'b1;
      measure(hi, lo);
      measure(hi, lo);
      `CHK("direct high", 3, hi)
      `CHK("direct pair", 10, hi + lo)
      $display("test direct done");
   endtask

   // every multiplying code at a 400 ns input period
   task automatic test_pll();
      logic [2:0] codes [6] = '{3'b111, 3'b110, 3'b101, 3'b100, 3'b010, 3'b000};
      int halves [6] = '{8, 6, 4, 10, 3, 5};
      int rises, mn, mx;
      foreach (codes[i])
      begin
         load_mode(codes[i]);
         oscHigh = 200;
         oscLow = 200;
         oscRun = 1'b1;
         repeat (1500) @(negedge clk);
         rises = 0;
         mn = 999;
         mx = 0;
         repeat (500)
         begin
            @(negedge clk);
            rises += (cpuRise === 1'b1);
            if (cpuRise === 1'b1 || cpuFall === 1'b1)
            begin
               mn = clockHalfPeriod < mn ? clockHalfPeriod : mn;
               mx = clockHalfPeriod > mx ? clockHalfPeriod : mx;
            end
         end
         `CHK("pll rate", 1'b1, rises >= 5 * halves[i] - 2 && rises <= 5 * halves[i] + 2)
         `CHK("pll smooth", 1'b1, mx - mn <= 3)
      end
      $display("test pll done");
   endtask

   // reset, then the scenarios in turn
   initial
   begin
      err_total = 0;
      num_checks = 0;
      rst = 1'b1;
      longHwReset = 1'b0;
      reloadFromSoftware = 1'b0;
      resetControlReg = 16'h0000;
      port0UpperByte = 8'hff;
      oscRun = 1'b0;
      oscHigh = 24;
      oscLow = 56;
      repeat (8) @(negedge clk);
      rst = 1'b0;
      @(negedge clk);
      `CHK("latch reset", 8'hff, resetConfigLatch)
      `CHK("pll reset", 1'b1, pllEnable)
      test_hw_reset();
      test_prescaler();
      test_direct();
      test_pll();
      finish_test();
   end

   // watchdog against a hang
   initial
   begin
      repeat (30000) @(posedge clk);
      err_total++;
      finish_test();
   end
endmodule

bind cpu_clock_mode_select cpu_clock_mode_select_monitor mon (.clk, .rst, .longHwReset, .reloadFromSoftware,
   .resetControlReg, .port0UpperByte, .oscIn, .resetConfigLatch, .clockGenSelectField, .pllEnable, .directDrive,
   .prescalerOn, .cpuClk, .cpuRise, .cpuFall);
